// file: rtl/margin_cmd_pkg.sv
// Purpose: shared constants and carriers for the margin and section-verify command engine
// Assumes: 16-bit parameter words, 23-bit global address, one-word data flash reads at byte addresses
// Notes:   block map sizes are plain defaults; adjust for the real array
package margin_cmd_pkg;

    // command codes carried in the high byte of parameter word 0
    localparam logic [7:0] CMD_USER_MARGIN  = 8'h0d;
    localparam logic [7:0] CMD_FIELD_MARGIN = 8'h0e;
    localparam logic [7:0] CMD_SECT_VERIFY  = 8'h10;

    // word index expected at launch
    localparam logic [2:0] IDX_MARGIN = 3'h1;
    localparam logic [2:0] IDX_VERIFY = 3'h2;

    // margin settings
    localparam logic [15:0] LVL_NORMAL   = 16'h0000;
    localparam logic [15:0] LVL_USER_MAX = 16'h0002;
    localparam logic [15:0] LVL_FIELD_MAX = 16'h0004;
    localparam logic [2:0]  LVL_RESET    = 3'h0;

    // block map: global address [22:16] values
    localparam int          NUM_BLOCKS      = 2;
    localparam logic [6:0]  DFLASH_BLK_ID   = 7'h10;
    localparam logic [6:0]  PFLASH_BLK_ID   = 7'h7f;
    localparam logic [15:0] DFLASH_BASE     = 16'h0000;
    localparam logic [16:0] DFLASH_END      = 17'h01000; // one past last byte
    localparam int          DFLASH_IDX      = 0;
    localparam int          PFLASH_IDX      = 1;

    // erased-state word value
    localparam logic [15:0] ERASED_WORD = 16'hffff;

    // loaded parameter words
    typedef struct packed {
        logic [15:0] w0;
        logic [15:0] w1;
        logic [15:0] w2;
    } cmd_words_s;

    // error and verify flags reported back to the status register
    typedef struct packed {
        logic access_error;
        logic protection_violation;
        logic verify_error;
        logic verify_uncorrectable;
    } status_flags_s;

    // data flash read answer: ECC flags and data word
    typedef struct packed {
        logic        ecc_corrected;
        logic        ecc_uncorrectable;
        logic [15:0] data;
    } flash_rdata_s;

endpackage

// file: rtl/margin_level_reg.sv
// Purpose: margin level holder for one flash block
// Assumes: level written only from the command engine clock domain
// Notes:   reset returns the block to normal reads
`timescale 1ns/10ps
module margin_level_reg
    import margin_cmd_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       reset_i,
    input  wire logic       load_i,
    input  wire logic [2:0] level_i,
    output logic      [2:0] level_o
);

    logic [2:0] level_r;

    // level stays until reloaded or reset
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
            level_r <= LVL_RESET;
        else if (load_i)
            level_r <= level_i;
    end

    assign level_o = level_r;

endmodule

// file: rtl/margin_verify_cmd.sv
// Purpose: executes set user margin, set field margin and data flash section erase-verify
// Assumes: parameter words, index and launch come from the register file on this clock
// Notes:   launch is a one-cycle pulse for software clearing command_complete_flag
//
// Contract
// - code 0d sets user margin per block
// - apply user level, then set complete
// - user settings 0, 1, 2 only
// - user: index, mode, block, level errors
// - code 0e field margin, special mode only
// - apply field level, then set complete
// - field settings 0 through 4 accepted
// - field: same errors, no other flags
// - verify words: code, start, count layout
// - verify reads range, then sets complete
// - verify: index, mode, address errors
// - verify: odd start address is error
// - verify: range past block end error
// - verify sets verify flags on errors
// - clearing complete launches, set when done
`timescale 1ns/10ps
module margin_verify_cmd
    import margin_cmd_pkg::*;
(
    input  wire logic                clk_i,
    input  wire logic                reset_i,
    input  wire logic                launch_i,
    input  wire logic [2:0]          command_word_index_i,
    input  wire cmd_words_s          command_parameter_words_i,
    input  wire logic                special_mode_i,
    input  wire logic                cmd_allowed_i,
    output logic                     command_complete_flag_o,
    output status_flags_s            flags_o,
    output logic      [2:0]          dflash_margin_o,
    output logic      [2:0]          pflash_margin_o,
    output logic                     rd_req_o,
    output logic      [15:0]         rd_addr_o,
    input  wire logic                rd_ack_i,
    input  wire flash_rdata_s        rd_data_i
);

    typedef enum logic [1:0] {IDLE, READ, WAIT_ACK} state_e;

    state_e        state_r;
    state_e        state_nxt;
    logic          complete_r;
    status_flags_s flags_r;
    logic [15:0]   addr_r;
    logic [15:0]   remain_r;

    // field decode of the loaded words
    wire logic [7:0]  cmd_code  = command_parameter_words_i.w0[15:8];
    wire logic [6:0]  blk_id    = command_parameter_words_i.w0[6:0];
    wire logic [15:0] lvl       = command_parameter_words_i.w1;
    wire logic [15:0] start     = command_parameter_words_i.w1;
    wire logic [15:0] count     = command_parameter_words_i.w2;

    wire logic is_user   = (cmd_code == CMD_USER_MARGIN);
    wire logic is_field  = (cmd_code == CMD_FIELD_MARGIN);
    wire logic is_verify = (cmd_code == CMD_SECT_VERIFY);
    wire logic is_margin = is_user | is_field;

    wire logic blk_is_d  = (blk_id == DFLASH_BLK_ID);
    wire logic blk_is_p  = (blk_id == PFLASH_BLK_ID);
    wire logic blk_ok    = blk_is_d | blk_is_p;

    // user limits to 2, field to 4
    wire logic lvl_ok    = is_field ? (lvl <= LVL_FIELD_MAX) : (lvl <= LVL_USER_MAX);

    // field command only in special mode
    wire logic mode_ok   = cmd_allowed_i & (~is_field | special_mode_i);

    // byte span of the section, one word is two bytes; 17 bits to see overflow
    wire logic [16:0] span    = {count, 1'b0};
    // 18 bits: a full 16-bit count on a high start must not wrap back into range
    wire logic [17:0] sect_end = {2'b00, start} + {1'b0, span};
    wire logic in_dflash = (start >= DFLASH_BASE) & ({1'b0, start} < DFLASH_END);
    wire logic fits      = (sect_end <= {1'b0, DFLASH_END}) & (count != 16'h0000);

    // error on launch, per command
    wire logic margin_err = (command_word_index_i != IDX_MARGIN) | ~mode_ok | ~blk_ok | ~lvl_ok;
    wire logic verify_err = (command_word_index_i != IDX_VERIFY) | ~mode_ok | ~blk_is_d
                            | ~in_dflash | start[0] | ~fits;
    // unknown codes are refused too
    wire logic launch_err = is_margin ? margin_err : (is_verify ? verify_err : 1'b1);

    wire logic take       = launch_i & complete_r & (state_r == IDLE);
    wire logic apply_lvl  = take & is_margin & ~launch_err;
    wire logic start_ver  = take & is_verify & ~launch_err;
    wire logic last_word  = (remain_r == 16'h0001);
    wire logic word_bad   = (rd_data_i.data != ERASED_WORD) | rd_data_i.ecc_corrected
                            | rd_data_i.ecc_uncorrectable;
    // an answer counts in either read state, so an early ack is never lost
    wire logic reading    = (state_r == READ) | (state_r == WAIT_ACK);
    wire logic rd_take    = reading & rd_ack_i;

    // per-block margin holders, level held until reload or reset
    margin_level_reg u_dflash_lvl
    (
        .clk_i   (clk_i),
        .reset_i (reset_i),
        .load_i  (apply_lvl & blk_is_d),
        .level_i (lvl[2:0]),
        .level_o (dflash_margin_o)
    );

    margin_level_reg u_pflash_lvl
    (
        .clk_i   (clk_i),
        .reset_i (reset_i),
        .load_i  (apply_lvl & blk_is_p),
        .level_i (lvl[2:0]),
        .level_o (pflash_margin_o)
    );

    // verify walk: one read per word
    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            IDLE:     if (start_ver) state_nxt = READ;
            READ:     state_nxt = rd_ack_i ? (last_word ? IDLE : READ) : WAIT_ACK;
            WAIT_ACK: if (rd_ack_i) state_nxt = last_word ? IDLE : READ;
        endcase
    end

    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
            state_r <= IDLE;
        else
            state_r <= state_nxt;
    end

    // address and remaining-word counters
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            addr_r   <= 16'h0000;
            remain_r <= 16'h0000;
        end
        else if (start_ver)
        begin
            addr_r   <= start;
            remain_r <= count;
        end
        else if (rd_take)
        begin
            addr_r   <= addr_r + 16'h0002;
            remain_r <= remain_r - 16'h0001;
        end
    end

    // complete flag: low while busy, high when done; error completes at once
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
            complete_r <= 1'b1;
        else if (take & (launch_err | apply_lvl))
            complete_r <= 1'b1;
        else if (take)
            complete_r <= 1'b0;
        else if (rd_take && last_word)
            complete_r <= 1'b1;
    end

    // status flags cleared at launch; protection flag never set here
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
            flags_r <= '0;
        else if (take)
        begin
            flags_r                      <= '0;
            flags_r.access_error         <= launch_err;
        end
        else if (rd_take)
        begin
            if (word_bad)
                flags_r.verify_error         <= 1'b1;
            if (rd_data_i.ecc_uncorrectable)
                flags_r.verify_uncorrectable <= 1'b1;
        end
    end

    // read port; request held until acknowledged
    assign rd_req_o  = reading;
    assign rd_addr_o = addr_r;

    assign command_complete_flag_o = complete_r;
    assign flags_o                 = flags_r;

endmodule

// file: sim/margin_verify_cmd_sva.sv
// Purpose: port checks for the margin and section-verify engine
// Assumes: one clock, async active-high reset
// Notes:   a launch counts only while the complete flag is high
`timescale 1ns/10ps
module margin_verify_cmd_sva
    import margin_cmd_pkg::*;
(
    input wire logic          clk_i,
    input wire logic          reset_i,
    input wire logic          launch_i,
    input wire logic [2:0]    command_word_index_i,
    input wire cmd_words_s    command_parameter_words_i,
    input wire logic          special_mode_i,
    input wire logic          cmd_allowed_i,
    input wire logic          command_complete_flag_o,
    input wire status_flags_s flags_o,
    input wire logic [2:0]    dflash_margin_o,
    input wire logic [2:0]    pflash_margin_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);
    // launch decode; the section end is kept wide so it cannot wrap
    wire        go = launch_i && command_complete_flag_o;
    wire [7:0]  cd = command_parameter_words_i.w0[15:8];
    wire [15:0] lv = command_parameter_words_i.w1;
    wire [2:0]  l3 = lv[2:0];
    wire        um = go && cd == CMD_USER_MARGIN;
    wire        fm = go && cd == CMD_FIELD_MARGIN;
    wire        sv = go && cd == CMD_SECT_VERIFY;
    wire        ok = cmd_allowed_i && command_parameter_words_i.w0[6:0] == DFLASH_BLK_ID;
    wire [17:0] ed = {2'b00, lv} + {1'b0, command_parameter_words_i.w2, 1'b0};
    wire        ae = flags_o.access_error;
    wire        dn = command_complete_flag_o;
    AST_USER_SET: assert property (um && ok && command_word_index_i == IDX_MARGIN
        && lv <= LVL_USER_MAX |=> dflash_margin_o == $past(l3) && dn && !ae) else $error("user");
    AST_FIELD_SET: assert property (fm && ok && special_mode_i && lv <= LVL_FIELD_MAX
        && command_word_index_i == IDX_MARGIN |=> dflash_margin_o == $past(l3) && !ae) else $error("field");
    AST_USER_LEVEL: assert property (um && lv > LVL_USER_MAX
        |=> ae && dn && $stable(dflash_margin_o) && $stable(pflash_margin_o)) else $error("level");
    AST_MARGIN_REFUSE: assert property ((um || fm) && command_word_index_i != IDX_MARGIN
        || fm && !special_mode_i |=> ae && dn) else $error("refuse");
    AST_NO_PROTECT: assert property (!flags_o.protection_violation) else $error("protect");
    AST_ODD_START: assert property (sv && lv[0] |=> ae && dn) else $error("odd");
    AST_PAST_END: assert property (sv && ed > {1'b0, DFLASH_END} |=> ae) else $error("end");
    AST_VERIFY_RUN: assert property (sv && ok && command_word_index_i == IDX_VERIFY && !lv[0]
        && ed <= {1'b0, DFLASH_END} && ed != {2'b00, lv} |=> !dn) else $error("run");
    AST_HOLD: assert property (!launch_i ##1 !launch_i
        |=> $stable(dflash_margin_o) && $stable(pflash_margin_o)) else $error("hold");
endmodule
bind margin_verify_cmd margin_verify_cmd_sva u_sva (.clk_i(clk_i), .reset_i(reset_i),
    .launch_i(launch_i), .command_word_index_i(command_word_index_i),
    .command_parameter_words_i(command_parameter_words_i), .special_mode_i(special_mode_i),
    .cmd_allowed_i(cmd_allowed_i), .command_complete_flag_o(command_complete_flag_o),
    .flags_o(flags_o), .dflash_margin_o(dflash_margin_o), .pflash_margin_o(pflash_margin_o));

// file: sim/flash_margin_verify_cmds_tb_top.sv
// Purpose: self-checking bench for the margin and section-verify engine
// Assumes: bench answers flash reads itself at a random pace
// Notes:   expectations come from an integer model, never from outputs
`timescale 1ns/10ps
module flash_margin_verify_cmds_tb_top
    import margin_cmd_pkg::*;
();
    logic          clk_i = 0, reset_i = 1, launch_i = 0, sp = 0, al = 1, ack = 0, vb, vu, nz;
    logic [2:0]    idx = 0, dmar, pmar;
    logic [7:0]    rc;
    logic [15:0]   ea, rd_addr;
    logic          complete, rd_req;
    cmd_words_s    words = '0;
    flash_rdata_s  rdat = '0;
    status_flags_s flags;
    int            errors = 0, checks_done = 0, cyc = 0, nrd, dm = 0, pm = 0;

    margin_verify_cmd dut (.clk_i(clk_i), .reset_i(reset_i), .launch_i(launch_i),
        .command_word_index_i(idx), .command_parameter_words_i(words), .special_mode_i(sp),
        .cmd_allowed_i(al), .command_complete_flag_o(complete), .flags_o(flags),
        .dflash_margin_o(dmar), .pflash_margin_o(pmar), .rd_req_o(rd_req),
        .rd_addr_o(rd_addr), .rd_ack_i(ack), .rd_data_i(rdat));

    always #25 clk_i = ~clk_i;

    task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            errors++;
            $display("ERROR %0t got %h want %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // one command: model outcome, launch, wait for completion, compare
    task automatic cmd(input logic [7:0] c, input logic [6:0] b, input logic [15:0] a, n,
                       input logic [2:0] x, input logic s, o);
        logic e, mg, v;
        int t;
        mg = c == CMD_USER_MARGIN || c == CMD_FIELD_MARGIN;
        e = !o || (mg ? x != 1 || (c == CMD_FIELD_MARGIN && !s) || (b != DFLASH_BLK_ID
            && b != PFLASH_BLK_ID) || a > (c == CMD_FIELD_MARGIN ? 4 : 2) : c != CMD_SECT_VERIFY
            || x != 2 || b != DFLASH_BLK_ID || a[0] || n == 0 || a + 2 * n > 32'h1000);
        v = c == CMD_SECT_VERIFY && !e;
        vb = 0;
        vu = 0;
        nrd = 0;
        ea = a;
        nz = 1'($urandom);
        words = {c, 1'b0, b, a, n};
        idx = x;
        sp = s;
        al = o;
        launch_i = 1;
        @(posedge clk_i);
        #2 launch_i = 0;
        @(posedge clk_i);
        #2 chk(18'(complete), 18'(!v));
        for (t = 0; complete !== 1'b1 && t < 300; t++)
            @(posedge clk_i) #2;
        if (mg && !e && b == DFLASH_BLK_ID)
            dm = a;
        if (mg && !e && b == PFLASH_BLK_ID)
            pm = a;
        chk(18'({complete, flags}), {13'h0, 1'b1, e, 1'b0, vb, vu});
        chk(18'({dmar, pmar}), 18'({dm[2:0], pm[2:0]}));
        chk(18'(nrd), v ? 18'(n) : 18'h0);
    endtask

    // read responder; between answers the data lines toggle
    always @(posedge clk_i)
    begin
        #2;
        if (rd_req && !ack && $urandom % 2)
        begin
            rdat = nz ? {$urandom % 8 == 0, $urandom % 8 == 0,
                   $urandom % 4 ? ERASED_WORD : 16'($urandom)} : {2'b00, ERASED_WORD};
            vb |= rdat != {2'b00, ERASED_WORD};
            vu |= rdat.ecc_uncorrectable;
            chk(18'(rd_addr), 18'(ea));
            ea += 2;
            nrd++;
            ack = 1;
        end
        else
        begin
            ack = 0;
            rdat = ~rdat;
        end
    end

    // hang guard, far above the few hundred cycles needed
    always @(posedge clk_i)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            errors++;
            end_of_test();
        end
    end

    initial
    begin
        void'($urandom(57528));
        repeat (3) @(posedge clk_i);
        #2 reset_i = 0;
        // both codes, levels 0..5, both blocks, mode off then on
        for (int i = 0; i < 48; i++)
            cmd(i % 2 ? CMD_FIELD_MARGIN : CMD_USER_MARGIN, i % 4 > 1 ? PFLASH_BLK_ID :
                DFLASH_BLK_ID, 16'((i / 4) % 6), 0, 1, i > 23, 1);
        cmd(CMD_USER_MARGIN, 7'h22, 1, 0, 1, 1, 1); // no such block
        cmd(CMD_USER_MARGIN, DFLASH_BLK_ID, 2, 0, 1, 1, 0); // permission refuses
        cmd(CMD_FIELD_MARGIN, PFLASH_BLK_ID, 3, 0, 0, 1, 1); // wrong index
        cmd(CMD_SECT_VERIFY, DFLASH_BLK_ID, 16'h0ffc, 2, 2, 0, 1); // last words
        cmd(CMD_SECT_VERIFY, DFLASH_BLK_ID, 16'h0ffe, 2, 2, 0, 1); // one too far
        cmd(CMD_SECT_VERIFY, DFLASH_BLK_ID, 16'h0011, 1, 2, 0, 1); // odd start
        cmd(CMD_SECT_VERIFY, 7'h11, 16'h0100, 4, 1, 0, 0); // block, index and permission wrong
        // random codes, fields and read answers
        for (int i = 0; i < 60; i++)
        begin
            rc = i % 4 == 0 ? CMD_USER_MARGIN : i % 4 == 1 ? CMD_FIELD_MARGIN :
                 i % 4 == 2 ? CMD_SECT_VERIFY : 8'($urandom);
            cmd(rc, $urandom % 5 ? DFLASH_BLK_ID : 7'($urandom), rc == CMD_SECT_VERIFY ?
                16'($urandom % 'h1004) : 16'($urandom % 6), 16'($urandom % 12),
                $urandom % 6 ? (rc == CMD_SECT_VERIFY ? 3'h2 : 3'h1) : 3'($urandom),
                1'($urandom), $urandom % 8 != 0);
        end
        // a reset after a completed field command returns both blocks to normal reads
        // field level only as a one-off factory check, then reset back
        cmd(CMD_FIELD_MARGIN, PFLASH_BLK_ID, 4, 0, 1, 1, 1);
        reset_i = 1;
        @(posedge clk_i);
        #2 reset_i = 0;
        dm = 0;
        pm = 0;
        chk(18'({complete, flags, dmar, pmar}), 18'h400);
        cmd(CMD_USER_MARGIN, PFLASH_BLK_ID, 1, 0, 1, 0, 1);
        end_of_test();
    end
endmodule
